// File: core/sdpwm_cfg.svh
// offsets, field positions, reset values and counts of the dual pwm drive
`ifndef SDPWM_CFG_SVH
`define SDPWM_CFG_SVH
// ****************************************
// register addresses (7-bit serial address)
// ****************************************
`define SDPWM_ADDR_CH1    7'h08
`define SDPWM_ADDR_CH2    7'h09
`define SDPWM_ADDR_CMD    7'h0A
// ****************************************
// drive register fields
// ****************************************
`define SDPWM_OP_HI       31
`define SDPWM_OP_LO       30
`define SDPWM_PER_HI      29
`define SDPWM_PER_LO      19
`define SDPWM_DUTY_HI     18
`define SDPWM_DUTY_LO     8
`define SDPWM_DRIVE_MASK  32'hFFFF_FF00
`define SDPWM_DRIVE_RST   32'h0000_0000
// ****************************************
// command word update-hold bits
// ****************************************
`define SDPWM_HOLD1_BIT   29
`define SDPWM_HOLD2_BIT   26
// ****************************************
// operation codes
// ****************************************
`define SDPWM_OP_OFF      2'h0
`define SDPWM_OP_FWD      2'h1
`define SDPWM_OP_REV      2'h2
`define SDPWM_OP_BRAKE    2'h3
// ****************************************
// base divider last count (ratio minus one)
// ****************************************
`define SDPWM_DIV_LAST_1  5'h00
`define SDPWM_DIV_LAST_2  5'h01
`define SDPWM_DIV_LAST_4  5'h03
`define SDPWM_DIV_LAST_20 5'h13
`define SDPWM_CNT_RST     11'h000
`endif

// File: core/sdpwm_pkg.sv
// types shared by the dual pwm drive modules
`include "sdpwm_cfg.svh"
package sdpwm_pkg;
  // motor operation code
  typedef enum logic [1:0] {
    OP_OFF   = `SDPWM_OP_OFF,
    OP_FWD   = `SDPWM_OP_FWD,
    OP_REV   = `SDPWM_OP_REV,
    OP_BRAKE = `SDPWM_OP_BRAKE
  } sdpwm_op_e;
  // decoded settings of one channel
  typedef struct packed {
    sdpwm_op_e   op;
    logic [10:0] period;
    logic [10:0] duty;
  } sdpwm_drive_s;
  // level and enable of the two outputs of one bridge
  typedef struct packed {
    logic first_lvl;
    logic first_oe;
    logic second_lvl;
    logic second_oe;
  } sdpwm_pair_s;
  // state of one channel generator
  typedef struct packed {
    logic [4:0]  div_cnt;
    logic [10:0] cnt;
    sdpwm_pair_s out;
  } sdpwm_chan_st_s;
  // state of the top level
  typedef struct packed {
    logic             ext_s1;
    logic             ext_s2;
    logic             ext_prev;
    logic [1:0]       isel_s1;
    logic [1:0]       isel_s2;
    logic [3:0]       pwm_s1;
    logic [3:0]       pwm_s2;
    logic [1:0]       hold;
    logic [1:0][31:0] drv;
    logic [1:0][31:0] act;
    logic [31:0]      rdata;
  } sdpwm_top_st_s;
endpackage : sdpwm_pkg

// File: core/sdpwm_chan.sv
// one pwm channel: base divider, period counter and bridge output decode
`include "sdpwm_cfg.svh"
module sdpwm_chan (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ext_edge,
  input  wire logic [1:0]             div_sel,
  input  wire sdpwm_pkg::sdpwm_drive_s drive,
  input  wire logic                   spi_mode,
  input  wire logic                   brake_high,
  input  wire logic [1:0]             pin_pair,
  output sdpwm_pkg::sdpwm_pair_s      pair_out
);
  // ****************************************
  // helpers
  // ****************************************
  // last divider count for the selected base ratio
  function automatic logic [4:0] div_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: div_last = `SDPWM_DIV_LAST_1;
      2'h1: div_last = `SDPWM_DIV_LAST_2;
      2'h2: div_last = `SDPWM_DIV_LAST_4;
      2'h3: div_last = `SDPWM_DIV_LAST_20;
    endcase
  endfunction : div_last

  // on phase: zero duty never, duty at or above period always
  function automatic logic on_phase(input logic [10:0] duty,
                                    input logic [10:0] period,
                                    input logic [10:0] cnt);
    if (duty == 11'h000)
      on_phase = 1'b0;                          // RQ9
    else if (duty >= period)
      on_phase = 1'b1;                          // RQ7 RQ8
    else
      on_phase = cnt < duty;                    // RQ6 RQ16
  endfunction : on_phase

  sdpwm_pkg::sdpwm_chan_st_s s_reg;             // registered state
  sdpwm_pkg::sdpwm_chan_st_s s_next;            // next state
  logic                      tick;              // base tick enable
  logic                      on_now;            // current on phase

  // base tick: every ratio-th edge of the external clock
  assign tick   = ext_edge && (s_reg.div_cnt >= div_last(div_sel)); // RQ4 RQ5
  assign on_now = on_phase(drive.duty, drive.period, s_reg.cnt);
  assign pair_out = s_reg.out;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // divider counts external edges
    if (ext_edge) begin
      s_next.div_cnt = tick ? 5'h00 : 5'(s_reg.div_cnt + 5'h01); // RQ4
    end
    // period counter 0..period then wrap
    if (tick) begin
      if (s_reg.cnt >= drive.period)
        s_next.cnt = `SDPWM_CNT_RST;            // RQ3 RQ16
      else
        s_next.cnt = 11'(s_reg.cnt + 11'h001);  // RQ16
    end
    // output decode
    if (!spi_mode) begin
      // pin control: register settings do not apply
      s_next.out = '{pin_pair[0], 1'b1, pin_pair[1], 1'b1}; // RQ13
    end else begin
      unique case (drive.op)
        sdpwm_pkg::OP_OFF:   s_next.out = '0;                    // RQ1
        sdpwm_pkg::OP_FWD:   s_next.out = '{on_now, 1'b1,
                                            1'b0, 1'b1};          // RQ1
        sdpwm_pkg::OP_REV:   s_next.out = '{1'b0, 1'b1,
                                            on_now, 1'b1};        // RQ1
        sdpwm_pkg::OP_BRAKE: s_next.out = '{brake_high, 1'b1,
                                            brake_high, 1'b1};    // RQ2
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_off;
    spi_mode && drive.op == sdpwm_pkg::OP_OFF
      |=> !pair_out.first_oe && !pair_out.second_oe;
  endproperty
  a_off: assert property (p_off) // RQ1
    else $error("outputs not released in off mode");

  property p_brake;
    spi_mode && drive.op == sdpwm_pkg::OP_BRAKE
      |=> pair_out.first_lvl == $past(brake_high)
          && pair_out.second_lvl == $past(brake_high) && pair_out.first_oe;
  endproperty
  a_brake: assert property (p_brake) // RQ2
    else $error("brake side wrong");

  property p_wrap;
    tick && s_reg.cnt >= drive.period |=> s_reg.cnt == `SDPWM_CNT_RST;
  endproperty
  a_wrap: assert property (p_wrap) // RQ3
    else $error("period counter did not wrap");

  property p_step;
    tick && s_reg.cnt < drive.period |=> s_reg.cnt == $past(s_reg.cnt) + 11'h001;
  endproperty
  a_step: assert property (p_step) // RQ16
    else $error("period counter did not advance");

  // an external edge that is not a base tick must advance the divider
  property p_div1;
    ext_edge && !tick
      |=> s_reg.div_cnt == 5'($past(s_reg.div_cnt) + 5'h01);
  endproperty
  a_div1: assert property (p_div1) // RQ4
    else $error("base divider did not count an edge");

  property p_zero;
    spi_mode && drive.op == sdpwm_pkg::OP_FWD && drive.duty == 11'h000
      |=> !pair_out.first_lvl && pair_out.second_oe;
  endproperty
  a_zero: assert property (p_zero) // RQ9
    else $error("zero duty produced on phase");

  property p_full;
    spi_mode && drive.op == sdpwm_pkg::OP_REV && drive.duty != 11'h000
      && drive.duty >= drive.period |=> pair_out.second_lvl;
  endproperty
  a_full: assert property (p_full) // RQ8
    else $error("full duty dropped on phase");

  c_fwd_on: cover property (spi_mode && drive.op == sdpwm_pkg::OP_FWD
                            ##1 pair_out.first_lvl);
  c_wrap: cover property (tick && s_reg.cnt >= drive.period
                          && drive.period != 11'h000);
endmodule : sdpwm_chan

// File: core/sdpwm_top.sv
// dual pwm drive: serial-addressed registers and two pwm channels
//
// Summary of operation
// RQ1: op code: off, forward, reverse, brake
// RQ2: brake side chosen by general setup bit
// RQ3: pwm rate is base tick over period+1
// RQ4: base tick is divided external clock
// RQ5: divider codes give 1, 2, 4, 20
// RQ6: duty equals duty count over period+1
// RQ7: duty equal to period gives full on
// RQ8: duty above period still full on
// RQ9: zero duty count never turns on
// RQ10: software keeps duty not above period
// RQ11: period bits 29:19, duty bits 18:8
// RQ12: channel one at 0x08, two at 0x09
// RQ13: settings apply only under serial control
// RQ14: 7-bit address, fields reset zero, read/write
// RQ15: hold bit defers writes until zero written
// RQ16: counter 0..period, on while below duty
`include "sdpwm_cfg.svh"
module sdpwm_top (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ser_wr,
  input  wire logic             ser_rd,
  input  wire logic [6:0]       ser_addr,
  input  wire logic [31:0]      ser_wdata,
  output logic [31:0]           ser_rdata,
  input  wire logic             ext_clk_pin,
  input  wire logic [1:0]       isel_pin,
  input  wire logic [3:0]       pwm_pin,
  input  wire logic [1:0][1:0]  base_div,
  input  wire logic [1:0]       brake_high,
  output sdpwm_pkg::sdpwm_pair_s bridge_output_ab,
  output sdpwm_pkg::sdpwm_pair_s bridge_output_cd
);
  // ****************************************
  // helpers
  // ****************************************
  // split a drive register into its fields
  function automatic sdpwm_pkg::sdpwm_drive_s to_drive(input logic [31:0] w);
    to_drive.op     = sdpwm_pkg::sdpwm_op_e'(w[`SDPWM_OP_HI:`SDPWM_OP_LO]);
    to_drive.period = w[`SDPWM_PER_HI:`SDPWM_PER_LO];   // RQ11
    to_drive.duty   = w[`SDPWM_DUTY_HI:`SDPWM_DUTY_LO]; // RQ11
  endfunction : to_drive

  sdpwm_pkg::sdpwm_top_st_s s_reg;          // registered state
  sdpwm_pkg::sdpwm_top_st_s s_next;         // next state
  sdpwm_pkg::sdpwm_pair_s   pair_out [2];   // channel outputs
  logic                     ext_edge;       // external clock rising edge

  // edge seen on the second synchroniser stage only
  assign ext_edge         = s_reg.ext_s2 && !s_reg.ext_prev;
  assign ser_rdata        = s_reg.rdata;
  assign bridge_output_ab = pair_out[0];
  assign bridge_output_cd = pair_out[1];

  // ****************************************
  // register file and synchronisers
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // pins pass two flops before use
    s_next.ext_s1   = ext_clk_pin;
    s_next.ext_s2   = s_reg.ext_s1;
    s_next.ext_prev = s_reg.ext_s2;
    s_next.isel_s1  = isel_pin;
    s_next.isel_s2  = s_reg.isel_s1;
    s_next.pwm_s1   = pwm_pin;
    s_next.pwm_s2   = s_reg.pwm_s1;
    // writes at the 7-bit address
    if (ser_wr) begin
      case (ser_addr)                                       // RQ14
        `SDPWM_ADDR_CH1: begin
          s_next.drv[0] = ser_wdata & `SDPWM_DRIVE_MASK;     // RQ12
          if (!s_reg.hold[0]) begin
            s_next.act[0] = ser_wdata & `SDPWM_DRIVE_MASK;   // RQ15
          end
        end
        `SDPWM_ADDR_CH2: begin
          s_next.drv[1] = ser_wdata & `SDPWM_DRIVE_MASK;     // RQ12
          if (!s_reg.hold[1]) begin
            s_next.act[1] = ser_wdata & `SDPWM_DRIVE_MASK;   // RQ15
          end
        end
        `SDPWM_ADDR_CMD: begin
          // zero in a hold bit applies the written settings
          s_next.hold[0] = ser_wdata[`SDPWM_HOLD1_BIT];
          s_next.hold[1] = ser_wdata[`SDPWM_HOLD2_BIT];
          if (!ser_wdata[`SDPWM_HOLD1_BIT]) begin
            s_next.act[0] = s_reg.drv[0];                    // RQ15
          end
          if (!ser_wdata[`SDPWM_HOLD2_BIT]) begin
            s_next.act[1] = s_reg.drv[1];                    // RQ15
          end
        end
        default: begin
          // other addresses belong elsewhere
        end
      endcase
    end
    // reads return the written value with bits 7:0 cleared, zero elsewhere
    if (ser_rd) begin
      case (ser_addr)
        `SDPWM_ADDR_CH1: s_next.rdata = s_reg.drv[0];       // RQ14
        `SDPWM_ADDR_CH2: s_next.rdata = s_reg.drv[1];       // RQ14
        default:         s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register, all fields reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;                                          // RQ14
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  // software keeps duty within period; above it the channel runs full on
  for (genvar i = 0; i < 2; i++) begin : g_chan
    sdpwm_chan u_chan (
      .clk        (clk),
      .rst        (rst),
      .ext_edge   (ext_edge),
      .div_sel    (base_div[i]),
      .drive      (to_drive(s_reg.act[i])),
      .spi_mode   (s_reg.isel_s2[i]),                       // RQ13
      .brake_high (brake_high[i]),                          // RQ2
      .pin_pair   (s_reg.pwm_s2[2*i+1 -: 2]),
      .pair_out   (pair_out[i])
    );
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_wr1;
    ser_wr && ser_addr == `SDPWM_ADDR_CH1 && !s_reg.hold[0]
      |=> s_reg.act[0] == ($past(ser_wdata) & `SDPWM_DRIVE_MASK);
  endproperty
  a_wr1: assert property (p_wr1) // RQ12
    else $error("channel one write not applied");

  property p_hold;
    ser_wr && ser_addr == `SDPWM_ADDR_CH2 && s_reg.hold[1]
      |=> $stable(s_reg.act[1]);
  endproperty
  a_hold: assert property (p_hold) // RQ15
    else $error("held write reached channel two");

  property p_release;
    ser_wr && ser_addr == `SDPWM_ADDR_CMD && !ser_wdata[`SDPWM_HOLD1_BIT]
      |=> s_reg.act[0] == $past(s_reg.drv[0]) && !s_reg.hold[0];
  endproperty
  a_release: assert property (p_release) // RQ15
    else $error("release did not apply channel one");

  property p_rd2;
    ser_rd && ser_addr == `SDPWM_ADDR_CH2 |=> ser_rdata == $past(s_reg.drv[1]);
  endproperty
  a_rd2: assert property (p_rd2) // RQ14
    else $error("channel two readback wrong");

  property p_rd_other;
    ser_rd && ser_addr != `SDPWM_ADDR_CH1 && ser_addr != `SDPWM_ADDR_CH2
      |=> ser_rdata == 32'h0000_0000;
  endproperty
  a_rd_other: assert property (p_rd_other) // RQ14
    else $error("unmapped read not zero");

  c_release: cover property (s_reg.hold[0] ##1 !s_reg.hold[0]);
  c_brake: cover property (s_reg.act[1][`SDPWM_OP_HI:`SDPWM_OP_LO]
                           == `SDPWM_OP_BRAKE && s_reg.isel_s2[1]);
endmodule : sdpwm_top

// File: test/sdpwm_host.sv
// host model that drives the serial register port of the pwm drive
module sdpwm_host (
  input  wire logic        clk,
  output logic             ser_wr,
  output logic             ser_rd,
  output logic [6:0]       ser_addr,
  output logic [31:0]      ser_wdata,
  input  wire logic [31:0] ser_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    ser_wr    = 1'b0;
    ser_rd    = 1'b0;
    ser_addr  = 7'h7F;
    ser_wdata = 32'h0000_0000;
  end
  // one write, strobe held for a single edge; stale data is inverted
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    ser_wr    = 1'b1;
    ser_addr  = a;
    ser_wdata = d;
    @(posedge clk);
    #1;
    ser_wr    = 1'b0;
    ser_addr  = ~a;
    ser_wdata = ~d;
  endtask : wr
  // one read, data taken one edge after the strobe edge
  task automatic rd(input logic [6:0] a, output logic [31:0] d);
    @(posedge clk);
    #1;
    ser_rd   = 1'b1;
    ser_addr = a;
    @(posedge clk);
    #1;
    ser_rd   = 1'b0;
    ser_addr = ~a;
    @(posedge clk);
    #1;
    d = ser_rdata;
  endtask : rd
endmodule : sdpwm_host

// File: test/sdpwm_tb_top.sv
// self-checking bench of the dual pwm drive
module sdpwm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk = 1'b0;         // system clock
  logic                   rst = 1'b1;         // async reset
  logic                   ext_clk_pin = 1'b0; // external tick source
  logic                   ser_wr, ser_rd;     // register strobes
  logic [6:0]             ser_addr;           // register address
  logic [31:0]            ser_wdata, ser_rdata, rv;
  logic [1:0]             isel_pin = 2'h3;    // serial control
  logic [3:0]             pwm_pin = 4'h0;     // pin levels
  logic [1:0][1:0]        base_div = '0;      // divider codes
  logic [1:0]             brake_high = 2'h0;  // brake side
  sdpwm_pkg::sdpwm_pair_s ab, cd;             // bridge outputs
  int                     error_cnt = 0;
  int                     check_count = 0;
  int                     hi, tot;
  // ****************************************
  // clocks: 100 MHz system, 12.5 MHz external
  // ****************************************
  always #5 clk = ~clk;
  always #40 ext_clk_pin = ~ext_clk_pin;
  sdpwm_host host (.clk(clk), .ser_wr(ser_wr), .ser_rd(ser_rd),
    .ser_addr(ser_addr), .ser_wdata(ser_wdata), .ser_rdata(ser_rdata));
  sdpwm_top uut (.clk(clk), .rst(rst), .ser_wr(ser_wr), .ser_rd(ser_rd),
    .ser_addr(ser_addr), .ser_wdata(ser_wdata), .ser_rdata(ser_rdata),
    .ext_clk_pin(ext_clk_pin), .isel_pin(isel_pin), .pwm_pin(pwm_pin),
    .base_div(base_div), .brake_high(brake_high),
    .bridge_output_ab(ab), .bridge_output_cd(cd));
  // ****************************************
  // helpers
  // ****************************************
  // step to just after the n-th next rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick
  // compare one value and count it
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg,
               got, exp);
    end
  endtask : cmp
  // drive register word from op, period and duty
  function automatic logic [31:0] word(input logic [1:0] op,
    input logic [10:0] per, input logic [10:0] duty);
    return {op, per, duty, 8'h00};
  endfunction : word
  // pwm output of a channel: a on channel one, d on channel two
  function automatic logic lvl(input bit ch);
    return ch ? cd.second_lvl : ab.first_lvl;
  endfunction : lvl
  // one full pwm cycle of a channel: cycles on and cycles total
  task automatic meas(input bit ch, output int h, output int t);
    bit seen0;
    seen0 = 0;
    h = 0;
    t = 0;
    while (lvl(ch) !== 1'b0 && t < 3000) begin
      tick(1);
      t++;
    end
    while (lvl(ch) !== 1'b1 && t < 3000) begin
      tick(1);
      t++;
    end
    t = 0;
    while (!(seen0 && lvl(ch) === 1'b1) && t < 3000) begin
      if (lvl(ch) === 1'b1) h++;
      else seen0 = 1;
      t++;
      tick(1);
    end
  endtask : meas
  // cycles with output a on, over n cycles
  task automatic on_cnt(input int n, output int h);
    h = 0;
    repeat (n) begin
      tick(1);
      if (ab.first_lvl === 1'b1) h++;
    end
  endtask : on_cnt
  // ****************************************
  // scenarios
  // ****************************************
  // reset values of registers and outputs
  task automatic t_reset;
    host.rd(7'h08, rv);
    cmp(rv, 32'h0000_0000, "ch1 reset");
    host.rd(7'h09, rv);
    cmp(rv, 32'h0000_0000, "ch2 reset");
    cmp({ab, cd}, 32'h0000_0000, "outputs off after reset");
    $display("test reset done");
  endtask : t_reset
  // field layout, addresses, unmapped accesses
  task automatic t_regs;
    host.wr(7'h08, 32'hFFFF_FFFF);
    host.rd(7'h08, rv);
    cmp(rv, 32'hFFFF_FF00, "ch1 readback");
    host.wr(7'h09, word(2'h2, 11'h5A5, 11'h3C3));
    host.wr(7'h10, 32'h1234_5678);
    host.rd(7'h09, rv);
    cmp(rv, word(2'h2, 11'h5A5, 11'h3C3), "ch2 readback");
    host.rd(7'h08, rv);
    cmp(rv, 32'hFFFF_FF00, "ch1 kept");
    host.rd(7'h10, rv);
    cmp(rv, 32'h0000_0000, "unmapped read");
    $display("test registers done");
  endtask : t_regs
  // every op code on both channels, both brake sides, full duty
  task automatic t_ops;
    logic [3:0] exp;
    for (int ch = 0; ch < 2; ch++) begin
      for (int op = 0; op < 4; op++) begin
        for (int bh = 0; bh < 2; bh++) begin
          brake_high = {bh[0], bh[0]};
          host.wr(ch ? 7'h09 : 7'h08, word(op[1:0], 11'h004, 11'h004));
          tick(4);
          case (op)
            0: exp = 4'b0000;
            1: exp = 4'b1101;
            2: exp = 4'b0111;
            default: exp = bh ? 4'b1111 : 4'b0101;
          endcase
          cmp(ch ? cd : ab, exp, "op output");
        end
      end
    end
    $display("test op codes done");
  endtask : t_ops
  // pwm period and duty against every divider code
  task automatic t_duty;
    logic [10:0] per;
    logic [10:0] dty;
    int          ratio;
    for (int d = 0; d < 4; d++) begin
      base_div[0] = d[1:0];
      per = (d == 3) ? 11'h002 : 11'h003;
      dty = (d == 3) ? 11'h001 : 11'h002;
      ratio = (d == 0) ? 1 : (d == 1) ? 2 : (d == 2) ? 4 : 20;
      host.wr(7'h08, word(2'h1, per, dty));
      meas(1'b0, hi, tot);
      meas(1'b0, hi, tot);
      cmp(tot, (per + 1) * ratio * 8, "pwm cycle");
      cmp(hi, dty * ratio * 8, "on time");
    end
    // channel two in reverse on its own divider, quarter rate
    base_div[1] = 2'h2;
    host.wr(7'h09, word(2'h2, 11'h003, 11'h001));
    meas(1'b1, hi, tot);
    meas(1'b1, hi, tot);
    cmp(tot, 4 * 4 * 8, "ch2 pwm cycle");
    cmp(hi, 1 * 4 * 8, "ch2 on time");
    base_div[0] = 2'h0;
    host.wr(7'h08, word(2'h1, 11'h003, 11'h7FF));
    on_cnt(200, hi);
    cmp(hi, 200, "duty above period");
    host.wr(7'h08, word(2'h1, 11'h003, 11'h000));
    tick(4);
    on_cnt(200, hi);
    cmp(hi, 0, "zero duty");
    $display("test duty done");
  endtask : t_duty
  // held write reaches the output only when hold is cleared
  task automatic t_hold;
    host.wr(7'h08, word(2'h1, 11'h004, 11'h004));
    host.wr(7'h0A, 32'h2000_0000);
    host.wr(7'h08, word(2'h2, 11'h004, 11'h004));
    tick(4);
    cmp(ab, 4'b1101, "held output");
    host.rd(7'h08, rv);
    cmp(rv, word(2'h2, 11'h004, 11'h004), "held readback");
    host.wr(7'h0A, 32'h0000_0000);
    tick(4);
    cmp(ab, 4'b0111, "released output");
    // channel two holds on its own bit
    host.wr(7'h09, word(2'h1, 11'h004, 11'h004));
    host.wr(7'h0A, 32'h0400_0000);
    host.wr(7'h09, word(2'h2, 11'h004, 11'h004));
    tick(4);
    cmp(cd, 4'b1101, "ch2 held output");
    host.rd(7'h09, rv);
    cmp(rv, word(2'h2, 11'h004, 11'h004), "ch2 held readback");
    host.wr(7'h0A, 32'h0000_0000);
    tick(4);
    cmp(cd, 4'b0111, "ch2 released output");
    $display("test hold done");
  endtask : t_hold
  // pin control ignores register settings
  task automatic t_pin;
    isel_pin = 2'h0;
    pwm_pin = 4'b0011;
    tick(8);
    cmp({ab, cd}, 8'hF5, "pin control");
    isel_pin = 2'h3;
    tick(8);
    cmp(ab, 4'b0111, "back to serial");
    $display("test pin control done");
  endtask : t_pin
  // ****************************************
  // verdict
  // ****************************************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // watchdog against a hang
  initial begin
    #300000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_regs();
    t_ops();
    t_duty();
    t_hold();
    t_pin();
    end_of_test();
  end
endmodule : sdpwm_tb_top
